// [adc_conversion_control.sv]
// Behaviour
// (RQ1) both power-down pins low: bandgap, buffer and temperature sensor enabled
// (RQ2) ref power-down high, buffer low: reference off, buffer on
// (RQ3) both power-down pins high: reference and buffer off
// (RQ4) power-scaling mode drops to low power after each conversion
// (RQ5) digital interface stays active during acquisition and low power
// (RQ6) power-down pin waits for conversion end; bus stays active
// (RQ7) configuration power-down select overrides the power-down pin
// (RQ8) falling start edge begins a conversion, nothing else needed
// (RQ9) start edges and power-down ignored while converting
// (RQ10) start acts regardless of chip select and read strobe
// (RQ11) serial port shares pins with the parallel bus via select
// (RQ12) coding select picks twos complement or straight binary
// (RQ13) chip select or read high tristates interface outputs
// (RQ14) host uses chip select per device and read to enable data
// (RQ15) reset rising edge aborts conversion and tristates bus
// (RQ16) reset falling edge clears data bus and configuration
// (RQ17) select low picks parallel, high picks serial
// (RQ18) busy returning low marks result available
// (RQ19) busy high from start until latch; result updated only then
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control #(
    parameter int CONV_LEN = adc_ctrl_pkg::CONV_CYCLES
) (
    // clocking
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    // power and reference pins
    input wire logic ref_powerdown,
    input wire logic refbuf_powerdown,
    input wire logic powerdown_pin,
    input wire logic power_scaling_mode,
    // configuration port word
    input wire logic cfg_write,
    input wire logic [adc_ctrl_pkg::CFG_W-1:0] cfg_data,
    // conversion and read
    input wire logic conv_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic device_reset,
    input wire logic coding_select,
    input wire logic serial_parallel_select,
    input wire logic [adc_ctrl_pkg::RESULT_W-1:0] sar_result,
    // analogue enables
    output logic bandgap_en,
    output logic refbuf_en,
    output logic temp_en,
    output logic core_full_power,
    output logic powered_down,
    // status and bus
    output logic busy,
    output logic [adc_ctrl_pkg::RESULT_W-1:0] data_out,
    output logic data_oe,
    output logic serial_mode
);
    import adc_ctrl_pkg::*;

    conv_state_e state_reg;
    logic start_d_reg;
    logic reset_d_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CFG_W-1:0] cfg_reg;
    logic start_fall;
    logic reset_rise;
    logic reset_fall;
    logic pd_request;
    logic [RESULT_W-1:0] coded;
    result_if rif ();

    // ----------------------------------------------------------------
    // edge detection (pins are synchronous to clock)
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            start_d_reg <= 1'b1;
            reset_d_reg <= 1'b0;
        end else if (clk_en) begin
            start_d_reg <= conv_start_n;
            reset_d_reg <= device_reset;
        end
    end
    // start edge not qualified by cs_n or rd_n
    assign start_fall = start_d_reg & ~conv_start_n; // RQ8 RQ10
    assign reset_rise = ~reset_d_reg & device_reset;
    assign reset_fall = reset_d_reg & ~device_reset;
    // register bit selects the source of power-down
    assign pd_request = cfg_reg[CFG_PDSEL_BIT] ? cfg_reg[CFG_PD_BIT] : powerdown_pin; // RQ7

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cfg_reg <= CFG_RESET;
        end else if (clk_en) begin
            if (reset_fall) begin
                cfg_reg <= CFG_RESET; // RQ16
            end else if (cfg_write && !device_reset) begin
                cfg_reg <= cfg_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (device_reset) begin
                        state_reg <= ST_HELD;
                    end else if (start_fall && !pd_request) begin
                        state_reg <= ST_CONV; // RQ8
                        cnt_reg <= CNT_W'(CONV_LEN - 1);
                    end else if (pd_request) begin
                        state_reg <= ST_DOWN; // RQ6
                    end
                end
                ST_CONV: begin
                    // further starts are not looked at here; power-down is looked at only on the last count
                    if (reset_rise) begin
                        state_reg <= ST_HELD; // RQ15
                    end else if (cnt_reg == '0) begin
                        state_reg <= pd_request ? ST_DOWN : ST_IDLE; // RQ9 RQ6
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_DOWN: begin
                    if (device_reset) begin
                        state_reg <= ST_HELD;
                    end else if (!pd_request) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_HELD: begin
                    if (!device_reset) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // result path
    // ----------------------------------------------------------------
    // twos complement is the offset-binary word with the msb inverted
    assign coded = coding_select ? sar_result
                                 : {~sar_result[RESULT_W-1], sar_result[RESULT_W-2:0]}; // RQ12
    assign rif.sample = coded;
    assign rif.load = clk_en && state_reg == ST_CONV && cnt_reg == '0 && !reset_rise; // RQ19
    assign rif.clear = reset_fall; // RQ16

    result_store u_store (
        .clock(clock),
        .rstn(rstn),
        .clk_en(clk_en),
        .rif(rif)
    );

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bandgap_en <= 1'b0;
            refbuf_en <= 1'b0;
            temp_en <= 1'b0;
            core_full_power <= 1'b0;
            powered_down <= 1'b0;
        end else if (clk_en) begin
            bandgap_en <= ~ref_powerdown; // RQ1 RQ2 RQ3
            refbuf_en <= ~refbuf_powerdown; // RQ2 RQ3
            temp_en <= ~ref_powerdown & ~refbuf_powerdown; // RQ1
            // acquisition runs low power in scaling mode; logic unaffected
            core_full_power <= (state_reg == ST_CONV) || !power_scaling_mode; // RQ4 RQ5
            powered_down <= (state_reg == ST_DOWN);
        end
    end

    // bus control is independent of power state so it stays live
    always_ff @(posedge clock) begin
        if (!rstn) begin
            busy <= 1'b0;
            data_oe <= 1'b0;
            serial_mode <= 1'b0;
            data_out <= DATA_RESET;
        end else if (clk_en) begin
            busy <= (state_reg == ST_CONV) && !(cnt_reg == '0) && !reset_rise; // RQ19 RQ18
            data_oe <= !cs_n && !rd_n && !device_reset; // RQ13 RQ15 RQ5 RQ6
            serial_mode <= serial_parallel_select; // RQ11 RQ17
            data_out <= rif.data;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_busy_start;
        @(posedge clock) disable iff (!rstn)
        (clk_en && state_reg == ST_IDLE && start_fall && !pd_request && !device_reset)
            ##1 clk_en |=> busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised"); // RQ19

    property p_oe_gate;
        @(posedge clock) disable iff (!rstn)
        (clk_en && (cs_n || rd_n)) |=> !data_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("bus driven while deselected"); // RQ13

    property p_no_restart;
        @(posedge clock) disable iff (!rstn)
        (clk_en && state_reg == ST_CONV && cnt_reg != '0 && !reset_rise)
            |=> state_reg == ST_CONV && cnt_reg == $past(cnt_reg) - 1'b1;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion disturbed"); // RQ9

    property p_reset_abort;
        @(posedge clock) disable iff (!rstn)
        (clk_en && reset_rise) |=> state_reg == ST_HELD;
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort"); // RQ15

    property p_cfg_clear;
        @(posedge clock) disable iff (!rstn)
        (clk_en && reset_fall) |=> cfg_reg == CFG_RESET && rif.data == DATA_RESET;
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) else $error("reset did not clear"); // RQ16

    property p_temp;
        @(posedge clock) disable iff (!rstn)
        clk_en |=> temp_en == (!$past(ref_powerdown) && !$past(refbuf_powerdown));
    endproperty
    a_temp: assert property (p_temp) else $error("sensor enable wrong"); // RQ1

    property p_bufmode;
        @(posedge clock) disable iff (!rstn)
        (clk_en && ref_powerdown && !refbuf_powerdown) |=> !bandgap_en && refbuf_en;
    endproperty
    a_bufmode: assert property (p_bufmode) else $error("buffer mode wrong"); // RQ2

    property p_extref;
        @(posedge clock) disable iff (!rstn)
        (clk_en && ref_powerdown && refbuf_powerdown) |=> !bandgap_en && !refbuf_en;
    endproperty
    a_extref: assert property (p_extref) else $error("external mode wrong"); // RQ3

    // power-down only at the end of a conversion, never in the middle of one
    property p_pd_wait;
        @(posedge clock) disable iff (!rstn)
        (clk_en && state_reg == ST_CONV && !reset_rise)
            |=> (state_reg == ST_DOWN) == ($past(cnt_reg) == '0 && $past(pd_request));
    endproperty
    a_pd_wait: assert property (p_pd_wait) else $error("powered down mid conversion"); // RQ6

    // with the register in charge, the pin level must not decide the state
    property p_pdsel;
        @(posedge clock) disable iff (!rstn)
        (clk_en && state_reg == ST_IDLE && !device_reset && cfg_reg[CFG_PDSEL_BIT])
            |=> (state_reg == ST_DOWN) == $past(cfg_reg[CFG_PD_BIT]);
    endproperty
    a_pdsel: assert property (p_pdsel) else $error("pin not ignored"); // RQ7
endmodule
`default_nettype wire

// [adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
    // ----------------------------------------------------------------
    // widths and timing
    // ----------------------------------------------------------------
    localparam int RESULT_W = 14;
    localparam int CLK_MHZ = 50;
    localparam int CONV_TIME_NS = 700;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;
    // configuration word bit positions
    localparam int CFG_PD_BIT = 0;
    localparam int CFG_PDSEL_BIT = 1;
    localparam int CFG_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [13:0] DATA_RESET = 14'h0000;
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DOWN = 2'b10,
        ST_HELD = 2'b11
    } conv_state_e;
endpackage

// [result_if.sv]
`timescale 1ns/1ps
`default_nettype none
// result transfer between sequencer and output register
interface result_if;
    logic load;
    logic [13:0] sample;
    logic clear;
    logic [13:0] data;
    modport seq (output load, output sample, output clear, input data);
    modport store (input load, input sample, input clear, output data);
endinterface
`default_nettype wire

// [result_store.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// output result register
// ----------------------------------------------------------------
module result_store (
    // clocking
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    // transfer
    result_if.store rif
);
    import adc_ctrl_pkg::*;
    // holds its value between conversions; cleared on reset completion
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rif.data <= DATA_RESET;
        end else if (clk_en) begin
            if (rif.clear) begin
                rif.data <= DATA_RESET;
            end else if (rif.load) begin
                rif.data <= rif.sample;
            end
        end
    end
endmodule
`default_nettype wire

// [host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: start strobe and read strobes
module host_model (
    // clocking
    input wire logic clock,
    // strobes
    output logic conv_start_n,
    output logic cs_n,
    output logic rd_n
);
    // idle high so the first low is a real falling edge
    initial begin
        conv_start_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end
    // one-cycle low pulse, back high before any next start
    task automatic start_conv();
        conv_start_n = 1'b0;
        @(posedge clock);
        #1 conv_start_n = 1'b1;
    endtask
    // select and read levels, held until changed
    task automatic bus(input logic c, input logic r);
        cs_n = c;
        rd_n = r;
    endtask
endmodule
`default_nettype wire

// [adc_conversion_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_bench;
    import adc_ctrl_pkg::*;
    localparam int CL = 4; // short conversion keeps the run brief
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic ref_powerdown = 1'b0, refbuf_powerdown = 1'b0, powerdown_pin = 1'b0;
    logic power_scaling_mode = 1'b0, cfg_write = 1'b0, device_reset = 1'b0;
    logic clk_en = 1'b1;
    logic coding_select = 1'b1, serial_parallel_select = 1'b0;
    logic [CFG_W-1:0] cfg_data = '0;
    logic [RESULT_W-1:0] sar_result = '0;
    wire logic conv_start_n, cs_n, rd_n, bandgap_en, refbuf_en, temp_en;
    wire logic core_full_power, powered_down, busy, data_oe, serial_mode;
    wire logic [RESULT_W-1:0] data_out;
    logic [RESULT_W-1:0] exp_q[$];
    int bad_count = 0;
    int n_compared = 0;
    int bw = 0;
    // free-running 50 MHz clock
    always #10 clock = ~clock;
    host_model host (.clock, .conv_start_n, .cs_n, .rd_n);
    adc_conversion_control #(.CONV_LEN(CL)) DUT (
        .clock, .rstn, .clk_en, .ref_powerdown, .refbuf_powerdown,
        .powerdown_pin, .power_scaling_mode, .cfg_write, .cfg_data,
        .conv_start_n, .cs_n, .rd_n, .device_reset, .coding_select,
        .serial_parallel_select, .sar_result, .bandgap_en, .refbuf_en, .temp_en,
        .core_full_power, .powered_down, .busy, .data_out, .data_oe, .serial_mode
    );
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // sar value held until well after the latch point
    task automatic conv(input logic c, input logic r);
        sar_result = RESULT_W'($urandom);
        coding_select = 1'($urandom);
        host.bus(c, r);
        exp_q.push_back(coding_select ? sar_result : {~sar_result[13], sar_result[12:0]});
        host.start_conv();
        tick(CL + 3);
    endtask
    task automatic cfg(input logic [CFG_W-1:0] v);
        cfg_data = v;
        cfg_write = 1'b1;
        tick(1);
        cfg_write = 1'b0;
        tick(2);
    endtask
    // bus checked off once, CL + 2 edges into the pulse; held past any latch point, so an abort must leave no result
    task automatic rst_pulse(input logic [RESULT_W-1:0] held);
        device_reset = 1'b1;
        tick(2);
        chk(busy, 1'b0);
        tick(CL);
        chk(data_oe, 1'b0);
        chk(data_out, held);
        device_reset = 1'b0;
        tick(3);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // result monitor
    // ----------------------------------------
    // busy width in edges, settles one step after each edge
    always @(posedge clock) bw <= busy ? bw + 1 : 0;
    // aborted conversions leave no note, so skip them
    initial forever begin
        @(negedge busy);
        #1;
        if (rstn && !device_reset) begin
            chk(RESULT_W'(bw), RESULT_W'(CL - 1));
            repeat (2) @(posedge clock);
            #2;
            if (exp_q.size() == 0) chk(1'b1, 1'b0);
            else chk(data_out, exp_q.pop_front());
        end
    end
    // hang guard
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(2946));
        tick(2);
        rstn = 1'b1;
        tick(1);
        // reference modes: both low, reference off, both off
        for (int i = 0; i < 3; i++) begin
            {ref_powerdown, refbuf_powerdown} = 2'(i == 0 ? 0 : i + 1);
            tick(2);
            chk(bandgap_en, !ref_powerdown);
            chk(refbuf_en, !refbuf_powerdown);
            chk(temp_en, i == 0);
        end
        // frozen enable: a pin change must not reach the outputs
        clk_en = 1'b0;
        {ref_powerdown, refbuf_powerdown} = 2'b00;
        tick(2);
        chk(bandgap_en, 1'b0);
        clk_en = 1'b1;
        tick(2);
        chk(temp_en, 1'b1);
        {ref_powerdown, refbuf_powerdown} = 2'b11;
        power_scaling_mode = 1'b1;
        for (int i = 0; i < 8; i++) conv(1'($urandom), 1'($urandom));
        chk(core_full_power, 1'b0);
        // bus decode while in low power
        for (int i = 0; i < 4; i++) begin
            host.bus(i[1], i[0]);
            serial_parallel_select = i[0];
            tick(2);
            chk(data_oe, i == 0);
            chk(serial_mode, i[0]);
        end
        power_scaling_mode = 1'b0;
        tick(3);
        chk(core_full_power, 1'b1);
        // second start in mid-conversion must not stretch busy
        host.bus(1'b0, 1'b0);
        sar_result = 14'h2a5c;
        coding_select = 1'b1;
        exp_q.push_back(14'h2a5c);
        host.start_conv();
        tick(1);
        host.start_conv();
        tick(CL + 3);
        // power-down request lands while converting
        sar_result = 14'h1234;
        exp_q.push_back(14'h1234);
        host.start_conv();
        powerdown_pin = 1'b1;
        tick(CL + 3);
        chk(powered_down, 1'b1);
        host.start_conv();
        tick(2);
        chk(busy, 1'b0);
        chk(data_oe, 1'b1);
        cfg(8'h02);
        chk(powered_down, 1'b0);
        powerdown_pin = 1'b0;
        cfg(8'h03);
        chk(powered_down, 1'b1);
        rst_pulse(14'h1234);
        chk(powered_down, 1'b0);
        chk(data_out, DATA_RESET);
        // abort: no new result may appear
        host.start_conv();
        tick(1);
        rst_pulse(DATA_RESET);
        chk(data_out, DATA_RESET);
        // every noted result must have been seen
        chk(RESULT_W'(exp_q.size()), '0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
